// ---- rtl/vec_slot_map.sv ----
// holds: slot number to vector address and rom extent decode
// assumes: slot numbers come from the core's acknowledge logic
`timescale 1ns/100ps
`default_nettype none
module vec_slot_map
(
  // slot and size select
  input  wire logic [4:0]  i_slot,
  input  wire logic [7:0]  i_size_sel,
  // decoded results
  output logic      [15:0] o_vec_addr,
  output logic      [15:0] o_rom_top
);

  // slot n sits at byte 2*n, always inside 0000H..003FH
  assign o_vec_addr = {10'h000, i_slot, 1'b0}; // RL10 RL6

  always_comb
  begin
    unique case (i_size_sel) // RL4
      vecmap_pkg::MSS_8K:  o_rom_top = vecmap_pkg::ROM_TOP_8K;
      vecmap_pkg::MSS_16K: o_rom_top = vecmap_pkg::ROM_TOP_16K;
      vecmap_pkg::MSS_24K: o_rom_top = vecmap_pkg::ROM_TOP_24K;
      vecmap_pkg::MSS_32K: o_rom_top = vecmap_pkg::ROM_TOP_32K;
      default:             o_rom_top = vecmap_pkg::ROM_TOP_RESET;
    endcase
  end

endmodule // vec_slot_map
`default_nettype wire

// ---- rtl/vecmap_pkg.sv ----
// package: address map constants, vector slot table and carrier structs
// assumes: 64 KB byte-addressed space shared by program, data and registers
package vecmap_pkg;

  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 8;
  // vector table area
  localparam logic [15:0] VEC_BASE       = 16'h0000;
  localparam logic [15:0] VEC_LAST       = 16'h003F;
  localparam logic [15:0] RESET_VEC      = 16'h0000;
  localparam logic [15:0] BRK_VEC        = 16'h003E;
  localparam logic [15:0] SER6_TX_VEC    = 16'h0016;
  localparam logic [15:0] WATCH_INT_VEC  = 16'h0028;
  // memory size selection
  localparam logic [7:0]  MSS_RESET      = 8'hCF;
  localparam logic [7:0]  MSS_8K         = 8'h42;
  localparam logic [7:0]  MSS_16K        = 8'h44;
  localparam logic [7:0]  MSS_24K        = 8'hC6;
  localparam logic [7:0]  MSS_32K        = 8'hC8;
  // internal rom top addresses
  localparam logic [15:0] ROM_TOP_8K     = 16'h1FFF;
  localparam logic [15:0] ROM_TOP_16K    = 16'h3FFF;
  localparam logic [15:0] ROM_TOP_24K    = 16'h5FFF;
  localparam logic [15:0] ROM_TOP_32K    = 16'h7FFF;
  localparam logic [15:0] ROM_TOP_RESET  = 16'h7FFF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOW   = 3'b001,
    ST_HIGH  = 3'b010,
    ST_LOAD  = 3'b011,
    ST_RUN   = 3'b100
  } vec_state_t;

  // interrupt acknowledge from the core
  typedef struct packed {
    logic       ack;
    logic [4:0] slot;
  } irq_ack_t;

  // program memory read request
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } mem_req_t;

endpackage

// ---- rtl/vector_table_memory_map.sv ----
// holds: reset / interrupt vector fetch and program address source
// assumes: program memory answers a read one cycle after o_MEM_RD
// Notes on behaviour
// (RL1) one linear 64 KB address space holds program, data and registers.
// (RL2) memory size selection setting reads CFH after reset on every variant.
// (RL3) software programs the size setting to match installed rom capacity.
// (RL4) internal rom spans zero up to 1FFFH, 3FFFH, 5FFFH or 7FFFH.
// (RL5) instruction fetches normally take their address from the program counter.
// (RL6) bytes 0000H to 003FH are reserved for the vector table.
// (RL7) reset or acknowledged interrupt branches to that source's vector slot.
// (RL8) each vector stores low byte at even, high byte at odd address.
// (RL9) address zero slot is shared by all reset sources.
// (RL10) each interrupt source owns a fixed two-byte slot, e.g. 0016H, 0028H, 003EH.
// (RL11) on reset the program counter loads from bytes 0000H and 0001H.
// (RL12) both slot bytes are read, then pc loads before handler fetch.
`timescale 1ns/100ps
`default_nettype none
module vector_table_memory_map
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // reset sources sharing slot zero
  input  wire logic        i_EXT_RESET,
  input  wire logic        i_POWER_ON_CLEAR,
  input  wire logic        i_LOW_VOLTAGE_DETECT,
  input  wire logic        i_CLOCK_MONITOR,
  input  wire logic        i_WATCHDOG_RESET_SOURCE,
  // interrupt acknowledge
  input  wire vecmap_pkg::irq_ack_t i_IRQ,
  // core fetch side
  input  wire logic        i_PC_ADVANCE,
  input  wire logic [15:0] i_PC_STEP,
  input  wire logic        i_SIZE_WR,
  input  wire logic [7:0]  i_SIZE_DATA,
  // program memory
  input  wire logic [7:0]  i_MEM_DATA,
  output vecmap_pkg::mem_req_t o_MEM,
  // status
  output logic [15:0]      o_PC,
  output logic             o_PC_VALID,
  output logic             o_VEC_BUSY,
  output logic [7:0]       o_SIZE_SEL,
  output logic [15:0]      o_ROM_TOP,
  output logic             o_ADDR_IN_ROM
);

  vecmap_pkg::vec_state_t state_reg;
  vecmap_pkg::vec_state_t state_next;
  logic [15:0] pc_reg;
  logic [15:0] slot_addr_reg;
  logic [7:0]  low_byte_reg;
  logic [7:0]  size_reg;
  logic        any_reset;
  logic [15:0] vec_addr;
  logic [15:0] rom_top;

  // all reset sources share slot zero
  assign any_reset = i_EXT_RESET | i_POWER_ON_CLEAR | i_LOW_VOLTAGE_DETECT
                   | i_CLOCK_MONITOR | i_WATCHDOG_RESET_SOURCE; // RL9

  vec_slot_map u_map
  (
    .i_slot     (i_IRQ.slot),
    .i_size_sel (size_reg),
    .o_vec_addr (vec_addr),
    .o_rom_top  (rom_top)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      vecmap_pkg::ST_IDLE: state_next = vecmap_pkg::ST_LOW;
      vecmap_pkg::ST_LOW:  state_next = vecmap_pkg::ST_HIGH;
      vecmap_pkg::ST_HIGH: state_next = vecmap_pkg::ST_LOAD;
      vecmap_pkg::ST_LOAD: state_next = vecmap_pkg::ST_RUN; // RL12
      vecmap_pkg::ST_RUN:  if (i_IRQ.ack) state_next = vecmap_pkg::ST_LOW; // RL7
      default:             state_next = vecmap_pkg::ST_IDLE;
    endcase
    if (any_reset)
      state_next = vecmap_pkg::ST_IDLE;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      state_reg <= vecmap_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // slot address latched at reset or acknowledge
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      slot_addr_reg <= vecmap_pkg::RESET_VEC;
    else if (any_reset || state_reg == vecmap_pkg::ST_IDLE)
      slot_addr_reg <= vecmap_pkg::RESET_VEC; // RL11 RL9
    else if (state_reg == vecmap_pkg::ST_RUN && i_IRQ.ack)
      slot_addr_reg <= vec_addr; // RL7
  end

  // memory requests: even byte then odd byte, then pc fetches in run
  always_comb
  begin
    o_MEM.rd   = 1'b0;
    o_MEM.addr = pc_reg; // RL5
    if (state_reg == vecmap_pkg::ST_LOW)
    begin
      o_MEM.rd   = 1'b1;
      o_MEM.addr = slot_addr_reg; // RL8
    end
    else if (state_reg == vecmap_pkg::ST_HIGH)
    begin
      o_MEM.rd   = 1'b1;
      o_MEM.addr = slot_addr_reg | 16'h0001; // RL8
    end
    else if (state_reg == vecmap_pkg::ST_RUN)
      o_MEM.rd   = 1'b1;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      low_byte_reg <= 8'h00;
    else if (state_reg == vecmap_pkg::ST_HIGH)
      low_byte_reg <= i_MEM_DATA; // RL8
  end

  // 16-bit pc wraps within 64 KB
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      pc_reg <= 16'h0000;
    else if (state_reg == vecmap_pkg::ST_LOAD)
      pc_reg <= {i_MEM_DATA, low_byte_reg}; // RL12 RL11 RL8
    else if (state_reg == vecmap_pkg::ST_RUN && i_PC_ADVANCE && !i_IRQ.ack)
      pc_reg <= pc_reg + i_PC_STEP; // RL1 RL5
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      size_reg <= vecmap_pkg::MSS_RESET; // RL2
    else if (any_reset)
      size_reg <= vecmap_pkg::MSS_RESET; // RL2
    else if (i_SIZE_WR)
      size_reg <= i_SIZE_DATA; // RL3
  end

  assign o_PC          = pc_reg;
  assign o_PC_VALID    = (state_reg == vecmap_pkg::ST_RUN);
  assign o_VEC_BUSY    = (state_reg != vecmap_pkg::ST_RUN);
  assign o_SIZE_SEL    = size_reg;
  assign o_ROM_TOP     = rom_top;
  assign o_ADDR_IN_ROM = (pc_reg <= rom_top); // RL4

  a_reset_slot: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_reg == vecmap_pkg::ST_LOW |-> o_MEM.addr == slot_addr_reg) // RL7
    else $error("vector low byte read from wrong address");
  a_reset_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(any_reset) |=> slot_addr_reg == vecmap_pkg::RESET_VEC) // RL9
    else $error("reset did not select slot zero");
  a_size_reset: assert property (@(posedge I_CLK) disable iff (I_RST)
    any_reset |=> size_reg == vecmap_pkg::MSS_RESET) // RL2
    else $error("size setting not CFH after reset");
  a_odd_high: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_reg == vecmap_pkg::ST_LOW && !any_reset |=> o_MEM.addr[0] == 1'b1) // RL8
    else $error("high byte not read from odd address");
  a_pc_assemble: assert property (@(posedge I_CLK) disable iff (I_RST)
    state_reg == vecmap_pkg::ST_LOAD && !any_reset
      |=> pc_reg == {$past(i_MEM_DATA), $past(low_byte_reg)}) // RL12
    else $error("pc not loaded from vector bytes");
  a_vec_area: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_VEC_BUSY && o_MEM.rd |-> o_MEM.addr <= vecmap_pkg::VEC_LAST) // RL6
    else $error("vector read outside table");
  a_ack_sequence: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_PC_VALID && i_IRQ.ack && !any_reset
      |=> state_reg == vecmap_pkg::ST_LOW ##1 state_reg == vecmap_pkg::ST_HIGH) // RL7
    else $error("acknowledge did not start vector fetch");
  a_run_fetch: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_PC_VALID |-> o_MEM.addr == pc_reg) // RL5
    else $error("fetch address not from pc");
  a_brk_slot: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_PC_VALID && i_IRQ.ack && i_IRQ.slot == 5'h1F && !any_reset
      |=> slot_addr_reg == vecmap_pkg::BRK_VEC) // RL10
    else $error("break slot address wrong");
  a_rom_top: assert property (@(posedge I_CLK) disable iff (I_RST)
    size_reg == vecmap_pkg::MSS_8K |-> o_ROM_TOP == vecmap_pkg::ROM_TOP_8K) // RL4
    else $error("rom extent wrong for 8 KB");
  a_pc_width: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(o_PC_VALID) && $past(i_PC_ADVANCE) && o_PC_VALID && !$past(i_IRQ.ack)
      |-> pc_reg == 16'($past(pc_reg) + $past(i_PC_STEP))) // RL1
    else $error("pc did not wrap within 64 KB");

endmodule // vector_table_memory_map
`default_nettype wire

// ---- verification/vecmap_mem_model.sv ----
// holds: program memory model answering vector and pc fetches
// assumes: read data is due the cycle after a request
`timescale 1ns/100ps
`default_nettype none
module vecmap_mem_model
(
  // clock
  input  wire logic                 i_clk,
  // request and answer
  input  wire vecmap_pkg::mem_req_t i_mem,
  output logic      [7:0]           o_data
);
  initial o_data = 8'h3C;
  always @(posedge i_clk)
  begin
    if (i_mem.rd)
      o_data <= i_mem.addr[7:0] ^ i_mem.addr[15:8] ^ 8'hA5;
    else
      o_data <= ~o_data; // no stale byte between reads
  end
endmodule // vecmap_mem_model
`default_nettype wire

// ---- verification/vector_table_memory_map_bench.sv ----
// holds: self-checking bench for the vector fetch block
// assumes: memory model on the fetch side, 25 MHz clock
`timescale 1ns/100ps
`default_nettype none
module vector_table_memory_map_bench;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [4:0]           rsrc = 5'h00;
  vecmap_pkg::irq_ack_t irq = '0;
  logic                 adv = 1'b0;
  logic                 swr = 1'b0;
  logic [15:0]          step = 16'h0000;
  logic [7:0]           sdat = 8'h00;
  logic [7:0]           mdat;
  vecmap_pkg::mem_req_t mem;
  logic [15:0]          pc, top, top_e, e;
  logic                 valid, busy, inrom;
  logic [7:0]           ssel;
  logic [4:0]           s;
  logic [7:0]           codes [4] = '{8'h44, 8'hC6, 8'hC8, 8'h42};
  logic [15:0]          tops [4]  = '{16'h3FFF, 16'h5FFF, 16'h7FFF, 16'h1FFF};
  logic [4:0]           fixed [3] = '{5'h0B, 5'h14, 5'h1F};
  int                   err_total = 0;
  int                   checked = 0;
  int                   cyc = 0;

  always #20 clk = ~clk;

  vector_table_memory_map u_dut
  (
    .I_CLK(clk), .I_RST(rst), .i_EXT_RESET(rsrc[0]), .i_POWER_ON_CLEAR(rsrc[1]),
    .i_LOW_VOLTAGE_DETECT(rsrc[2]), .i_CLOCK_MONITOR(rsrc[3]),
    .i_WATCHDOG_RESET_SOURCE(rsrc[4]), .i_IRQ(irq), .i_PC_ADVANCE(adv),
    .i_PC_STEP(step), .i_SIZE_WR(swr), .i_SIZE_DATA(sdat), .i_MEM_DATA(mdat),
    .o_MEM(mem), .o_PC(pc), .o_PC_VALID(valid), .o_VEC_BUSY(busy),
    .o_SIZE_SEL(ssel), .o_ROM_TOP(top), .o_ADDR_IN_ROM(inrom)
  );
  vecmap_mem_model u_mem (.i_clk(clk), .i_mem(mem), .o_data(mdat));

  function automatic logic [15:0] vec(input logic [15:0] a);
    logic [15:0] h;
    h = a | 16'h0001;
    return {h[7:0] ^ h[15:8] ^ 8'hA5, a[7:0] ^ a[15:8] ^ 8'hA5};
  endfunction

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    chk("pc valid", 16'h0001, {15'h0, valid});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    void'($urandom(32'hd656));
    tick(3);
    rst = 1'b0;
    wait_valid();
    chk("reset pc", vec(16'h0000), pc);
    chk("size", 16'h00CF, {8'h00, ssel});
    chk("rom top", 16'h7FFF, top);
    for (int i = 0; i < 4; i++)
    begin
      swr = 1'b1;
      sdat = codes[i];
      tick(1);
      swr = 1'b0;
      tick(1);
      chk("rom top", tops[i], top);
    end
    top_e = 16'h1FFF;
    for (int i = 0; i < 11; i++)
    begin
      s = (i < 3) ? fixed[i] : 5'($urandom_range(31, 0));
      irq.ack = 1'b1;
      irq.slot = s;
      tick(1);
      chk("busy", 16'h0001, {15'h0, busy});
      chk("low addr", {10'h0, s, 1'b0}, mem.addr);
      chk("low rd", 16'h0001, {15'h0, mem.rd});
      // ack held with another slot: refused outside run
      irq.slot = ~s;
      tick(1);
      irq.ack = 1'b0;
      chk("high addr", {10'h0, s, 1'b1}, mem.addr);
      wait_valid();
      chk("vector pc", vec({10'h0, s, 1'b0}), pc);
      chk("in rom", {15'h0, pc <= top_e}, {15'h0, inrom});
      step = 16'($urandom_range(4, 1));
      e = pc + step;
      adv = 1'b1;
      tick(1);
      adv = 1'b0;
      chk("pc step", e, pc);
      chk("fetch addr", pc, mem.addr);
    end
    // corner: pc wraps past 64 KB into the 8 KB rom
    step = 16'h0100 - pc;
    e = 16'h0100;
    adv = 1'b1;
    tick(1);
    adv = 1'b0;
    chk("pc wrap", e, pc);
    chk("wrap in rom", 16'h0001, {15'h0, inrom});
    for (int i = 0; i < 5; i++)
    begin
      rsrc = 5'(1 << i);
      swr = 1'b1;
      sdat = 8'h44;
      tick(2);
      rsrc = 5'h00;
      swr = 1'b0;
      wait_valid();
      chk("source pc", vec(16'h0000), pc);
      chk("size", 16'h00CF, {8'h00, ssel});
    end
    give_verdict();
  end
endmodule // vector_table_memory_map_bench
`default_nettype wire
